// ==== hw/rsd_regs.svh ====
/*
 * Constants for the reset state and self-diagnostic block.
 * Assumes a 20 MHz core clock; included by bare name.
 */
`ifndef RSD_REGS_SVH
`define RSD_REGS_SVH

`define RSD_CLK_HZ          20000000
`define RSD_CMD_WAKE        8'h11
`define RSD_CMD_DIAG_READ   8'h0F
`define RSD_BIT_LOAD_OK     7
`define RSD_BIT_FUNC_OK     6
`define RSD_DIAG_RESET      8'h00
`define RSD_SPIKE_NS        20
`define RSD_SPIKE_CYC       ((`RSD_SPIKE_NS * 20 + 999) / 1000)
`define RSD_WAKE_SLEEP_MS   120
`define RSD_WAKE_AWAKE_MS   5
`define RSD_WAKE_SLEEP_CYC  (`RSD_WAKE_SLEEP_MS * 20000)
`define RSD_WAKE_AWAKE_CYC  (`RSD_WAKE_AWAKE_MS * 20000)
`define RSD_PWROFF_MS       120
`define RSD_PWROFF_CYC      (`RSD_PWROFF_MS * 20000)
`define RSD_RST_HOLD_US     10
`define RSD_RST_HOLD_CYC    (`RSD_RST_HOLD_US * 20)
`define RSD_SETTLE_CYC      4

`endif

// ==== hw/rsd_pkg.sv ====
/*
 * Types for the reset state and self-diagnostic block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package rsd_pkg;
    typedef logic [7:0] rsd_byte_type;
    typedef enum logic [1:0] {
        RSD_SLEEP = 2'b00,
        RSD_CHECK = 2'b01,
        RSD_AWAKE = 2'b11
    } rsd_state_type;
    typedef enum logic [1:0] {
        RSD_H_RESET = 2'b00,
        RSD_H_HOLD  = 2'b01,
        RSD_H_IDLE  = 2'b11,
        RSD_H_WAIT  = 2'b10
    } rsd_host_state_type;
endpackage

// ==== hw/rsd_link_if.sv ====
/*
 * Link between host and display device: reset, select, command, pins.
 * Assumes both ends share mclk_i; the bench resolves the tri-states.
 */
`timescale 1ns/100ps
interface rsd_link_if;
    logic       hw_reset_n_in;
    logic       chip_select_n_in;
    logic       cmd_valid;
    logic [7:0] cmd_code;
    logic       tearing_sync_out;
    logic       backlight_pwm_out;
    logic [23:0] parallel_data_bus_o;
    logic       parallel_data_bus_oe;
    logic       serial_data_out_o;
    logic       serial_data_out_oe;
    logic [7:0] diag_data;
    logic       diag_valid;
    logic       awake;

    modport dev (
        input  hw_reset_n_in, chip_select_n_in, cmd_valid, cmd_code,
        output tearing_sync_out, backlight_pwm_out, parallel_data_bus_o,
        output parallel_data_bus_oe, serial_data_out_o, serial_data_out_oe,
        output diag_data, diag_valid, awake
    );
    modport host (
        output hw_reset_n_in, chip_select_n_in, cmd_valid, cmd_code,
        input  tearing_sync_out, backlight_pwm_out, diag_data, diag_valid,
        input  awake
    );
endinterface

// ==== hw/rsd_device.sv ====
/*
 * Display device end: reset pin states, spike filter, wake diagnostics.
 * Assumes commands arrive synchronous to mclk_i, one per valid pulse.
 */
`timescale 1ns/100ps
`include "rsd_regs.svh"

module rsd_device #(
    parameter int SLEEP_WAIT_CYC = `RSD_WAKE_SLEEP_CYC,
    parameter int AWAKE_WAIT_CYC = `RSD_WAKE_AWAKE_CYC
) (
    // Clock and reset
    input  wire logic         mclk_i,
    input  wire logic         nrst_i,
    // Link
    rsd_link_if.dev           link,
    // Check results, software reset, pin sources and ready flag
    input  wire logic         otp_match_i,
    input  wire logic         func_ok_i,
    input  wire logic         soft_reset_i,
    input  wire logic         sync_pulse_i,
    input  wire logic         pwm_level_i,
    output logic              diag_ready_o
);
    import rsd_pkg::*;

    localparam int FLT = `RSD_SPIKE_CYC + 1;

    logic [1:0]         pin_raw;
    logic               rst_n_f;
    logic               cs_n_f;
    rsd_state_type      state;
    rsd_state_type      next_state;
    rsd_byte_type       diag;
    rsd_byte_type       next_diag;
    logic [22:0]        wait_cnt;
    logic [22:0]        next_wait_cnt;
    logic               ready;
    logic               next_ready;
    logic               te;
    logic               next_te;
    logic               pwm;
    logic               next_pwm;
    logic               dvalid;
    logic               next_dvalid;
    logic               in_reset;
    logic               cmd_ok;
    logic               wake_cmd;
    logic               read_cmd;
    logic               awake;
    logic               next_awake;

    function automatic logic all_same(input logic [FLT-1:0] v);
        logic ones;
        logic zeros;
        ones     = &v;
        zeros    = ~(|v);
        all_same = ones | zeros;
    endfunction

    // Command decode shared by both command paths
    function automatic logic cmd_is(input rsd_byte_type code,
                                    input rsd_byte_type want);
        cmd_is = (code == want);
    endfunction

    // Spike filters for reset and select, one per pin
    assign pin_raw = {link.chip_select_n_in, link.hw_reset_n_in};

    generate
        for (genvar g = 0; g < 2; g++) begin : g_flt
            logic [FLT-1:0] sh;
            logic           f;
            logic           next_f;

            always_comb begin
                next_f = f;
                if (all_same(sh)) begin
                    next_f = sh[0];
                end
            end

            // Power-on reads as pin low until samples agree
            always_ff @(posedge mclk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    sh <= '0;
                    f  <= 1'b0;
                end else begin
                    sh <= {sh[FLT-2:0], pin_raw[g]};
                    f  <= next_f;
                end
            end
        end
    endgenerate

    assign rst_n_f = g_flt[0].f;
    assign cs_n_f  = g_flt[1].f;

    // Reset regardless of select state
    assign in_reset = ~rst_n_f | soft_reset_i;
    assign cmd_ok   = link.cmd_valid & ~cs_n_f & ~in_reset;

    // Command decode
    assign wake_cmd = cmd_ok & cmd_is(link.cmd_code, `RSD_CMD_WAKE);
    assign read_cmd = cmd_ok & cmd_is(link.cmd_code, `RSD_CMD_DIAG_READ);

    // Wake sequencing, diagnostic bits and pin sources
    always_comb begin
        next_state    = state;
        next_diag     = diag;
        next_wait_cnt = wait_cnt;
        next_ready    = ready;
        next_te       = sync_pulse_i;
        next_pwm      = pwm_level_i;
        next_dvalid   = read_cmd;
        if (in_reset) begin
            next_state  = RSD_SLEEP;
            next_te     = 1'b0;
            next_pwm    = 1'b0;
            next_dvalid = 1'b0;
            next_ready  = 1'b0;
            next_wait_cnt = '0;
        end else begin
            case (state)
                RSD_SLEEP, RSD_AWAKE: begin
                    if (wake_cmd) begin
                        // Checks only on wake
                        if (otp_match_i) begin
                            next_diag[`RSD_BIT_LOAD_OK] =
                                ~diag[`RSD_BIT_LOAD_OK];
                        end
                        next_ready = 1'b0;
                        next_wait_cnt = (state == RSD_SLEEP) ?
                            23'(SLEEP_WAIT_CYC - 1) :
                            23'(AWAKE_WAIT_CYC - 1);
                        next_state = RSD_CHECK;
                    end
                end
                RSD_CHECK: begin
                    if (wait_cnt == '0) begin
                        if (func_ok_i) begin
                            next_diag[`RSD_BIT_FUNC_OK] =
                                ~diag[`RSD_BIT_FUNC_OK];
                        end
                        next_ready = 1'b1;
                        next_state = RSD_AWAKE;
                    end else begin
                        next_wait_cnt = wait_cnt - 23'd1;
                    end
                end
                default: next_state = RSD_SLEEP;
            endcase
        end
        next_awake = (next_state != RSD_SLEEP);
    end

    // State and output registers
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state    <= RSD_SLEEP;
            diag     <= `RSD_DIAG_RESET;
            wait_cnt <= '0;
            ready    <= 1'b0;
            te       <= 1'b0;
            pwm      <= 1'b0;
            dvalid   <= 1'b0;
            awake    <= 1'b0;
        end else begin
            state    <= next_state;
            diag     <= next_diag;
            wait_cnt <= next_wait_cnt;
            ready    <= next_ready;
            te       <= next_te;
            pwm      <= next_pwm;
            dvalid   <= next_dvalid;
            awake    <= next_awake;
        end
    end

    // Buses never driven by this block; sync, PWM, diagnostics and flags come from registers
    assign link.parallel_data_bus_o  = '0;
    assign link.parallel_data_bus_oe = 1'b0;
    assign link.serial_data_out_o    = 1'b0;
    assign link.serial_data_out_oe   = 1'b0;
    assign link.tearing_sync_out     = te;
    assign link.backlight_pwm_out    = pwm;
    assign link.diag_data            = diag;
    assign link.diag_valid           = dvalid;
    assign link.awake                = awake;
    assign diag_ready_o              = ready;
endmodule

// ==== hw/rsd_host.sv ====
/*
 * Host end: power-up reset hold, wake and diagnostic-read commands.
 * Assumes the device end shares mclk_i through rsd_link_if.
 */
`timescale 1ns/100ps
`include "rsd_regs.svh"

module rsd_host #(
    parameter int HOLD_CYC       = `RSD_RST_HOLD_CYC,
    parameter int SLEEP_WAIT_CYC = `RSD_WAKE_SLEEP_CYC,
    parameter int AWAKE_WAIT_CYC = `RSD_WAKE_AWAKE_CYC
) (
    // Clock and reset
    input  wire logic                  mclk_i,
    input  wire logic                  nrst_i,
    // Link
    rsd_link_if.host                   link,
    // User side
    input  wire logic                  wake_req_i,
    input  wire logic                  read_req_i,
    output logic                       busy_o,
    output rsd_pkg::rsd_byte_type      diag_o,
    output logic                       diag_valid_o
);
    import rsd_pkg::*;

    rsd_host_state_type state;
    rsd_host_state_type next_state;
    logic [22:0]        cnt;
    logic [22:0]        next_cnt;
    logic               rst_n;
    logic               next_rst_n;
    logic               cv;
    logic               next_cv;
    rsd_byte_type       code;
    rsd_byte_type       next_code;
    rsd_byte_type       dout;
    rsd_byte_type       next_dout;
    logic               dv;
    logic               next_dv;
    logic               busy;
    logic               next_busy;

    always_comb begin
        next_state = state;
        next_cnt   = cnt;
        next_rst_n = rst_n;
        next_cv    = 1'b0;
        next_code  = code;
        next_dout  = dout;
        next_dv    = link.diag_valid;
        if (link.diag_valid) begin
            next_dout = link.diag_data;
        end
        case (state)
            RSD_H_RESET: begin
                next_rst_n = 1'b0;
                next_cnt   = 23'(HOLD_CYC - 1);
                next_state = RSD_H_HOLD;
            end
            RSD_H_HOLD: begin
                if (cnt == '0) begin
                    next_rst_n = 1'b1;
                    next_cnt   = 23'(`RSD_SETTLE_CYC - 1);
                    next_state = RSD_H_WAIT;
                end else begin
                    next_cnt = cnt - 23'd1;
                end
            end
            RSD_H_IDLE: begin
                if (wake_req_i) begin
                    next_cv   = 1'b1;
                    next_code = `RSD_CMD_WAKE;
                    next_cnt  = link.awake ?
                        23'(AWAKE_WAIT_CYC) :
                        23'(SLEEP_WAIT_CYC);
                    next_state = RSD_H_WAIT;
                end else if (read_req_i) begin
                    next_cv   = 1'b1;
                    next_code = `RSD_CMD_DIAG_READ;
                end
            end
            RSD_H_WAIT: begin
                if (cnt == '0) begin
                    next_state = RSD_H_IDLE;
                end else begin
                    next_cnt = cnt - 23'd1;
                end
            end
            default: next_state = RSD_H_RESET;
        endcase
        next_busy = (next_state != RSD_H_IDLE);
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= RSD_H_RESET;
            cnt   <= '0;
            rst_n <= 1'b0;
            cv    <= 1'b0;
            code  <= 8'h00;
            dout  <= 8'h00;
            dv    <= 1'b0;
            busy  <= 1'b1;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            rst_n <= next_rst_n;
            cv    <= next_cv;
            code  <= next_code;
            dout  <= next_dout;
            dv    <= next_dv;
            busy  <= next_busy;
        end
    end

    // Select tied low
    assign link.chip_select_n_in = 1'b0;
    assign link.hw_reset_n_in    = rst_n;
    assign link.cmd_valid        = cv;
    assign link.cmd_code         = code;
    assign busy_o                = busy;
    assign diag_o                = dout;
    assign diag_valid_o          = dv;
endmodule

// ==== verification/rsd_props.sv ====
/*
 * Timing checks on the host to device link.
 * Assumes it sits beside rsd_link_if, on the same mclk_i and nrst_i.
 */
`timescale 1ns/100ps
`include "rsd_regs.svh"
module rsd_props #(
    parameter int SLEEP_WAIT_CYC = 20,
    parameter int AWAKE_WAIT_CYC = 5
) (
    // Clock and reset
    input  wire logic       mclk_i,
    input  wire logic       nrst_i,
    // Link
    input  wire logic       hw_reset_n_in,
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_code,
    input  wire logic       tearing_sync_out,
    input  wire logic       backlight_pwm_out,
    input  wire logic       parallel_data_bus_oe,
    input  wire logic       serial_data_out_oe,
    input  wire logic [7:0] diag_data,
    input  wire logic       diag_valid,
    input  wire logic       awake
);
    logic [7:0] since_wake;
    logic [7:0] next_since_wake;

    // Cycles since the last wake command
    always_comb begin
        next_since_wake = since_wake;
        if (cmd_valid && cmd_code == `RSD_CMD_WAKE) begin
            next_since_wake = 8'h00;
        end else if (since_wake != 8'hFF) begin
            next_since_wake = since_wake + 8'h01;
        end
    end

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            since_wake <= 8'hFF;
        end else begin
            since_wake <= next_since_wake;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!nrst_i);

    AST_SDO_IDLE: assert property (
        serial_data_out_oe == 1'b0)
        else $error("serial data out driven");
    AST_RESET_PINS: assert property (
        !hw_reset_n_in [*6] |-> !tearing_sync_out && !backlight_pwm_out
            && !parallel_data_bus_oe)
        else $error("pins not quiet in link reset");
    AST_RESET_SLEEP: assert property (
        !hw_reset_n_in [*6] |-> !awake)
        else $error("device awake in link reset");
    AST_RESET_REFUSES: assert property (
        !hw_reset_n_in [*4] ##0 cmd_valid |=> !diag_valid)
        else $error("command answered in link reset");
    AST_D7_AT_WAKE: assert property (
        $changed(diag_data[7]) |-> since_wake == 8'h00)
        else $error("bit 7 changed away from wake");
    AST_D6_NOT_EARLY: assert property (
        $changed(diag_data[6]) |-> since_wake >= AWAKE_WAIT_CYC)
        else $error("bit 6 changed too early");
    AST_D6_BOUNDED: assert property (
        $changed(diag_data[6]) |-> since_wake <= SLEEP_WAIT_CYC)
        else $error("bit 6 changed away from wake");
    AST_READ_ANSWER: assert property (
        diag_valid |-> $past(cmd_valid)
            && $past(cmd_code) == `RSD_CMD_DIAG_READ)
        else $error("diag answer without read");
    AST_SPIKE: assert property (
        awake && hw_reset_n_in ##1 !hw_reset_n_in ##1 hw_reset_n_in [*3]
            |-> awake)
        else $error("short reset pulse acted");
endmodule

// ==== verification/tb.sv ====
/*
 * Self-checking bench: host and device ends joined by rsd_link_if.
 * Assumes the design files and rsd_regs.svh are on the include path.
 */
`timescale 1ns/100ps
`define CHK(what, exp, got) begin \
    tests_run++; \
    if ((exp) !== (got)) begin \
        bad_count++; \
        $display("MISMATCH %s expected %h seen %h", what, exp, got); \
    end \
end
module tb;
    import rsd_pkg::*;
    logic         mclk_i = 1'b0;
    logic         nrst_i = 1'b0;
    logic         otp_match_i = 1'b1;
    logic         func_ok_i = 1'b1;
    logic         soft_reset_i = 1'b0;
    logic         sync_pulse_i = 1'b1;
    logic         pwm_level_i = 1'b1;
    logic         diag_ready_o;
    logic         wake_req_i = 1'b0;
    logic         read_req_i = 1'b0;
    logic         busy_o;
    rsd_byte_type diag_o;
    logic         diag_valid_o;
    rsd_byte_type exp_diag;
    int           bad_count = 0;
    int           tests_run = 0;

    always #25 mclk_i = ~mclk_i;

    rsd_link_if link_if();
    rsd_device #(.SLEEP_WAIT_CYC(20), .AWAKE_WAIT_CYC(5)) i_rsd_device (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .link(link_if),
        .otp_match_i(otp_match_i), .func_ok_i(func_ok_i),
        .soft_reset_i(soft_reset_i), .sync_pulse_i(sync_pulse_i),
        .pwm_level_i(pwm_level_i), .diag_ready_o(diag_ready_o));
    rsd_host #(.HOLD_CYC(12), .SLEEP_WAIT_CYC(20), .AWAKE_WAIT_CYC(5))
        i_rsd_host (
        .mclk_i(mclk_i), .nrst_i(nrst_i), .link(link_if),
        .wake_req_i(wake_req_i), .read_req_i(read_req_i), .busy_o(busy_o),
        .diag_o(diag_o), .diag_valid_o(diag_valid_o));
    rsd_props i_rsd_props (
        .mclk_i(mclk_i), .nrst_i(nrst_i),
        .hw_reset_n_in(link_if.hw_reset_n_in),
        .cmd_valid(link_if.cmd_valid), .cmd_code(link_if.cmd_code),
        .tearing_sync_out(link_if.tearing_sync_out),
        .backlight_pwm_out(link_if.backlight_pwm_out),
        .parallel_data_bus_oe(link_if.parallel_data_bus_oe),
        .serial_data_out_oe(link_if.serial_data_out_oe),
        .diag_data(link_if.diag_data), .diag_valid(link_if.diag_valid),
        .awake(link_if.awake));

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Output pins quiet and buses released
    task automatic pins_low();
        @(negedge mclk_i);
        `CHK("sync", 1'b0, link_if.tearing_sync_out)
        `CHK("pwm", 1'b0, link_if.backlight_pwm_out)
        `CHK("pdb_oe", 1'b0, link_if.parallel_data_bus_oe)
        `CHK("sdo_oe", 1'b0, link_if.serial_data_out_oe)
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            @(negedge mclk_i);
            n++;
        end while (busy_o !== 1'b0 && n < 200);
    endtask

    // Wake, then count cycles from command to bit 6 valid
    task automatic wake(input int lo, input int hi);
        int n;
        @(posedge mclk_i) wake_req_i <= 1'b1;
        @(posedge mclk_i) wake_req_i <= 1'b0;
        n = 0;
        do begin
            @(negedge mclk_i);
            n++;
        end while (link_if.cmd_valid !== 1'b1 && n < 60);
        n = 0;
        repeat (2) @(negedge mclk_i);
        while (diag_ready_o !== 1'b1 && n < 100) begin
            @(negedge mclk_i);
            n++;
        end
        `CHK("wait_lo", 1'b1, n + 2 > lo)
        `CHK("wait_hi", 1'b1, n + 2 < hi)
        wait_idle();
    endtask

    task automatic read_diag(input rsd_byte_type exp);
        int n;
        @(posedge mclk_i) read_req_i <= 1'b1;
        @(posedge mclk_i) read_req_i <= 1'b0;
        n = 0;
        do begin
            @(negedge mclk_i);
            n++;
        end while (diag_valid_o !== 1'b1 && n < 30);
        `CHK("diag_valid", 1'b1, diag_valid_o)
        `CHK("diag_o", exp, diag_o)
        wait_idle();
    endtask

    initial begin
        #1_000_000;
        bad_count++;
        print_verdict();
    end

    initial begin
        repeat (12) @(posedge mclk_i);
        nrst_i <= 1'b1;
        repeat (8) @(posedge mclk_i);
        pins_low();
        wait_idle();
        exp_diag = 8'h00;
        read_diag(exp_diag);
        `CHK("sync_on", 1'b1, link_if.tearing_sync_out)
        `CHK("pwm_on", 1'b1, link_if.backlight_pwm_out)
        wake(20, 40);
        exp_diag = exp_diag ^ 8'hC0;
        read_diag(exp_diag);
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk_i);
            otp_match_i <= i[1];
            func_ok_i <= i[0];
            wake(5, 20);
            exp_diag = exp_diag ^ {i[1], i[0], 6'h00};
            read_diag(exp_diag);
        end
        @(posedge mclk_i) soft_reset_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        pins_low();
        @(posedge mclk_i) soft_reset_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        read_diag(exp_diag);
        @(posedge mclk_i);
        otp_match_i <= 1'b1;
        func_ok_i <= 1'b1;
        wake(20, 40);
        exp_diag = exp_diag ^ 8'hC0;
        read_diag(exp_diag);
        print_verdict();
    end
endmodule
